// [return_address_stack.sv]
/*
 * Return address stack with pointer/status register and top-of-stack window,
 * reached by software over AXI4-Lite, and a fast shadow hidden from software.
 * Assumes the sequencer issues at most one stack operation per cycle and
 * resets the device when fault_reset pulses.
 */
// Summary of operation
// - Only top entry visible via three registers
// - Calls, interrupts, link ops push return address
// - Pointer ranges 0 to 31
// - Push increments first; pop reads first
// - Any device reset zeroes the pointer
// - Software reads and writes pointer field
// - Full flag after 31 unpopped pushes
// - Fault enable: 31st push stores, resets
// - Fault disabled: pointer sticks at 31
// - Empty pop gives zero, sets underflow
// - Fault enable selects flag-only or reset
// - Flags cleared by software or power-on
// - Pointer bits 4..0, bit 5 zero
// - Push instruction stores current counter
// - Pop instruction only decrements pointer
// - Hidden shadow loaded on interrupt vectoring
// - Fast return restores, fast call saves
// - Nested interrupt overwrites shadow
// - 31 entries of 21 bits
// - Pointer zero has no storage
// - Return loads counter then decrements
`timescale 1ns/1ns
module return_address_stack
    import ras_pkg::*;
#(
    parameter int unsigned ENTRIES = ras_pkg::DEPTH
) (
    input  wire logic                      mclk,
    input  wire logic                      nrst,
    input  wire logic                      por,
    input  wire logic                      dev_reset,
    input  wire ras_pkg::stack_op_type     op,
    input  wire logic                      op_fast,
    input  wire logic [ras_pkg::PC_W-1:0]  pc_in,
    input  wire logic [ras_pkg::SHADOW_W-1:0] live_regs,
    output logic      [ras_pkg::PC_W-1:0]  pc_out,
    output logic                           pc_load,
    output logic      [ras_pkg::SHADOW_W-1:0] shadow_regs,
    output logic                           shadow_load,
    output logic                           fault_reset,
    input  wire logic [ras_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic      [1:0]                s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [ras_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic      [31:0]               s_axi_rdata,
    output logic      [1:0]                s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready
);
    import ras_pkg::*;

    // The pointer must be able to address every entry
    if (ENTRIES < 1 || ENTRIES > (1 << PTR_W) - 1) begin : g_bad_entries
        $error("return_address_stack: ENTRIES out of range");
    end

    localparam logic [PTR_W-1:0] PTR_MAX = PTR_W'(ENTRIES);

    // Pointer and flags
    logic [PTR_W-1:0] ptr_r;
    logic [PTR_W-1:0] ptr_nxt;
    logic             full_r;
    logic             full_nxt;
    logic             unf_r;
    logic             unf_nxt;
    logic             fre_r;
    logic             fre_nxt;
    logic             fault_r;
    logic             fault_nxt;
    logic [PC_W-1:0]  pc_out_r;
    logic [PC_W-1:0]  pc_out_nxt;
    logic             pc_load_r;
    logic             pc_load_nxt;

    // RAM ports
    logic [PTR_W-1:0] wr_idx;
    logic [2:0]       wr_be;
    logic [PC_W-1:0]  wr_data;
    logic [PC_W-1:0]  top_data;

    // Bus state
    logic             aw_held_r;
    logic             aw_held_nxt;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [ADDR_W-1:0] aw_addr_nxt;
    logic             w_held_r;
    logic             w_held_nxt;
    logic [31:0]      w_data_r;
    logic [31:0]      w_data_nxt;
    logic [3:0]       w_strb_r;
    logic [3:0]       w_strb_nxt;
    logic             bvalid_r;
    logic             bvalid_nxt;
    logic [1:0]       bresp_r;
    logic [1:0]       bresp_nxt;
    logic             rvalid_r;
    logic             rvalid_nxt;
    logic [31:0]      rdata_r;
    logic [31:0]      rdata_nxt;
    logic [1:0]       rresp_r;
    logic [1:0]       rresp_nxt;

    logic             wr_fire;
    logic             sw_ptr_wr;
    logic             sw_cfg_wr;
    logic [2:0]       sw_top_be;
    logic             push_req;
    logic             pop_req;

    ras_entry_ram #(
        .ENTRIES (ENTRIES)
    ) u_ram (
        .mclk    (mclk),
        .wr_idx  (wr_idx),
        .wr_be   (wr_be),
        .wr_data (wr_data),
        .rd_idx  (ptr_r),
        .rd_data (top_data)
    );

    ras_fast_shadow u_shadow (
        .mclk          (mclk),
        .nrst          (nrst),
        .save          (op == OP_IRQ || (op == OP_CALL && op_fast)),
        .restore       (op == OP_RETURN && op_fast),
        .live_in       (live_regs),
        .shadow_out    (shadow_regs),
        .restore_valid (shadow_load)
    );

    // Write channel decode
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign wr_fire       = aw_held_r && w_held_r && !bvalid_r;
    assign sw_ptr_wr     = wr_fire && aw_addr_r == OFF_PTR && w_strb_r[0];
    assign sw_cfg_wr     = wr_fire && aw_addr_r == OFF_CONFIG && w_strb_r[0];
    assign sw_top_be     = {wr_fire && aw_addr_r == OFF_TOP_UPR && w_strb_r[0],
                            wr_fire && aw_addr_r == OFF_TOP_HIGH && w_strb_r[0],
                            wr_fire && aw_addr_r == OFF_TOP_LOW && w_strb_r[0]};

    always_comb begin
        aw_held_nxt = aw_held_r;
        aw_addr_nxt = aw_addr_r;
        w_held_nxt  = w_held_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = {s_axi_awaddr[ADDR_W-1:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            case (aw_addr_r)
                OFF_PTR, OFF_TOP_LOW, OFF_TOP_HIGH, OFF_TOP_UPR, OFF_CONFIG: begin
                    bresp_nxt = RESP_OKAY;
                end
                default: begin
                    bresp_nxt = RESP_SLVERR;
                end
            endcase
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    // Read channel
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = RESP_OKAY;
            case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
                OFF_PTR:      rdata_nxt = {24'h0, full_r, unf_r, 1'b0, ptr_r};
                OFF_TOP_LOW:  rdata_nxt = {24'h0, top_data[7:0]};
                OFF_TOP_HIGH: rdata_nxt = {24'h0, top_data[15:8]};
                OFF_TOP_UPR:  rdata_nxt = {27'h0, top_data[PC_W-1:16]};
                OFF_CONFIG:   rdata_nxt = {31'h0, fre_r};
                default: begin
                    rdata_nxt = 32'h0;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    // Stack core
    always_comb begin
        push_req    = op == OP_CALL || op == OP_PUSH || op == OP_IRQ;
        pop_req     = op == OP_RETURN || op == OP_POP;
        ptr_nxt     = ptr_r;
        full_nxt    = full_r;
        unf_nxt     = unf_r;
        fre_nxt     = fre_r;
        fault_nxt   = 1'b0;
        pc_out_nxt  = pc_out_r;
        pc_load_nxt = 1'b0;
        wr_idx      = '0;
        wr_be       = 3'b000;
        wr_data     = pc_in;
        if (sw_ptr_wr) begin
            ptr_nxt = w_data_r[PTR_W-1:0];
            if (!w_data_r[FULL_BIT]) begin
                full_nxt = 1'b0;
            end
            if (!w_data_r[UNF_BIT]) begin
                unf_nxt = 1'b0;
            end
        end
        if (sw_cfg_wr) begin
            fre_nxt = w_data_r[0];
        end
        if (sw_top_be != 3'b000) begin
            wr_idx  = ptr_r;
            wr_be   = sw_top_be;
            wr_data = {w_data_r[4:0], w_data_r[7:0], w_data_r[7:0]};
        end
        if (push_req) begin
            if (ptr_r < PTR_MAX) begin
                ptr_nxt = ptr_r + 1'b1;
                wr_idx  = ptr_r + 1'b1;
                wr_be   = 3'b111;
                wr_data = pc_in;
                if (ptr_r + 1'b1 == PTR_MAX) begin
                    full_nxt = 1'b1;
                    fault_nxt = fre_r;
                end
            end else begin
                full_nxt  = 1'b1;
                fault_nxt = fre_r;
            end
        end else if (pop_req) begin
            if (ptr_r == '0) begin
                unf_nxt   = 1'b1;
                fault_nxt = fre_r;
                if (op == OP_RETURN) begin
                    pc_out_nxt  = '0;
                    pc_load_nxt = 1'b1;
                end
            end else begin
                ptr_nxt = ptr_r - 1'b1;
                if (op == OP_RETURN) begin
                    pc_out_nxt  = top_data;
                    pc_load_nxt = 1'b1;
                end
            end
        end
        if (dev_reset) begin
            ptr_nxt = '0;
        end
        if (por) begin
            ptr_nxt  = '0;
            full_nxt = 1'b0;
            unf_nxt  = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ptr_r     <= PTR_REG_RST[PTR_W-1:0];
            full_r    <= PTR_REG_RST[FULL_BIT];
            unf_r     <= PTR_REG_RST[UNF_BIT];
            fre_r     <= FRE_RST;
            fault_r   <= 1'b0;
            pc_out_r  <= '0;
            pc_load_r <= 1'b0;
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_held_r  <= 1'b0;
            w_data_r  <= '0;
            w_strb_r  <= '0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
            rvalid_r  <= 1'b0;
            rdata_r   <= '0;
            rresp_r   <= RESP_OKAY;
        end else begin
            ptr_r     <= ptr_nxt;
            full_r    <= full_nxt;
            unf_r     <= unf_nxt;
            fre_r     <= fre_nxt;
            fault_r   <= fault_nxt;
            pc_out_r  <= pc_out_nxt;
            pc_load_r <= pc_load_nxt;
            aw_held_r <= aw_held_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_held_r  <= w_held_nxt;
            w_data_r  <= w_data_nxt;
            w_strb_r  <= w_strb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
        end
    end

    assign pc_out       = pc_out_r;
    assign pc_load      = pc_load_r;
    assign fault_reset  = fault_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;

endmodule // return_address_stack

// [ras_pkg.sv]
/*
 * Shared constants for the return address stack: register offsets on the
 * AXI4-Lite bus, field positions, reset values and operation codes.
 * Assumes a single 100 MHz clock domain and 32-bit bus data.
 */
package ras_pkg;

    localparam int unsigned DATA_W      = 32;
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned PC_W        = 21;
    localparam int unsigned PTR_W       = 5;
    localparam int unsigned DEPTH       = 31;
    localparam int unsigned SHADOW_W    = 24;

    // Register byte addresses
    localparam logic [7:0] OFF_PTR      = 8'h00;
    localparam logic [7:0] OFF_TOP_LOW  = 8'h04;
    localparam logic [7:0] OFF_TOP_HIGH = 8'h08;
    localparam logic [7:0] OFF_TOP_UPR  = 8'h0c;
    localparam logic [7:0] OFF_CONFIG   = 8'h10;

    // Pointer/status register fields
    localparam int unsigned FULL_BIT    = 7;
    localparam int unsigned UNF_BIT     = 6;
    localparam int unsigned ZERO_BIT    = 5;
    localparam logic [7:0]  PTR_REG_RST = 8'h00;
    // Fault reset enable defaults set
    localparam logic        FRE_RST     = 1'b1;

    localparam logic [1:0] RESP_OKAY    = 2'b00;
    localparam logic [1:0] RESP_SLVERR  = 2'b10;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_CALL,
        OP_RETURN,
        OP_PUSH,
        OP_POP,
        OP_IRQ
    } stack_op_type;

endpackage

// [ras_entry_ram.sv]
/*
 * Storage for the return address stack entries, indices 1..DEPTH.
 * Index zero has no storage and reads as zero. One write port with
 * per-byte enables, one asynchronous read port.
 */
`timescale 1ns/1ns
module ras_entry_ram
    import ras_pkg::*;
#(
    parameter int unsigned ENTRIES = ras_pkg::DEPTH
) (
    input  wire logic              mclk,
    input  wire logic [PTR_W-1:0]  wr_idx,
    input  wire logic [2:0]        wr_be,
    input  wire logic [PC_W-1:0]   wr_data,
    input  wire logic [PTR_W-1:0]  rd_idx,
    output logic      [PC_W-1:0]   rd_data
);
    logic [PC_W-1:0] mem [1:ENTRIES];

    // Storage must fit behind a nonzero pointer
    if (ENTRIES < 1 || ENTRIES > (1 << PTR_W) - 1) begin : g_bad_entries
        $error("ras_entry_ram: ENTRIES out of range");
    end

    always_ff @(posedge mclk) begin
        if (wr_idx != '0 && 32'(wr_idx) <= ENTRIES) begin
            if (wr_be[0]) begin
                mem[wr_idx][7:0] <= wr_data[7:0];
            end
            if (wr_be[1]) begin
                mem[wr_idx][15:8] <= wr_data[15:8];
            end
            if (wr_be[2]) begin
                mem[wr_idx][PC_W-1:16] <= wr_data[PC_W-1:16];
            end
        end
    end

    always_comb begin
        if (rd_idx == '0 || 32'(rd_idx) > ENTRIES) begin
            rd_data = '0;
        end else begin
            rd_data = mem[rd_idx];
        end
    end

endmodule // ras_entry_ram

// [ras_fast_shadow.sv]
/*
 * One-level shadow for status, working and bank-select registers.
 * Not visible to software; loaded on interrupt vectoring and fast calls.
 */
`timescale 1ns/1ns
module ras_fast_shadow
    import ras_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                nrst,
    input  wire logic                save,
    input  wire logic                restore,
    input  wire logic [SHADOW_W-1:0] live_in,
    output logic      [SHADOW_W-1:0] shadow_out,
    output logic                     restore_valid
);
    logic [SHADOW_W-1:0] shadow_r;
    logic [SHADOW_W-1:0] shadow_nxt;
    logic                rv_r;
    logic                rv_nxt;

    always_comb begin
        shadow_nxt = save ? live_in : shadow_r;
        rv_nxt     = restore;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            shadow_r <= '0;
            rv_r     <= 1'b0;
        end else begin
            shadow_r <= shadow_nxt;
            rv_r     <= rv_nxt;
        end
    end

    assign shadow_out    = shadow_r;
    assign restore_valid = rv_r;

endmodule // ras_fast_shadow

// [ras_checker_assertions.sv]
/*
 * Port-level checker for the return address stack.
 * Assumes the single mclk domain and asynchronous active-low nrst.
 */
`timescale 1ns/1ns
module ras_checker #(
    parameter int unsigned ENTRIES = 31
) (
    input wire logic                   mclk,
    input wire logic                   nrst,
    input wire logic                   por,
    input wire logic                   dev_reset,
    input wire ras_pkg::stack_op_type  op,
    input wire logic                   op_fast,
    input wire logic [23:0]            live_regs,
    input wire logic                   pc_load,
    input wire logic [23:0]            shadow_regs,
    input wire logic                   shadow_load,
    input wire logic                   fault_reset,
    input wire logic                   s_axi_awvalid,
    input wire logic                   s_axi_awready,
    input wire logic                   s_axi_wvalid,
    input wire logic                   s_axi_wready,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic [31:0]            s_axi_rdata,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_rready
);
    import ras_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_pc_load_cause:
        assert property (pc_load |-> $past(op) == OP_RETURN) else $error("stray pc_load");
    a_shadow_load_cause:
        assert property (shadow_load |-> $past(op == OP_RETURN && op_fast))
        else $error("stray shadow_load");
    a_shadow_capture:
        assert property ((op == OP_IRQ || (op == OP_CALL && op_fast)) && !por && !dev_reset
        |=> shadow_regs == $past(live_regs)) else $error("shadow not saved");
    a_fault_cause:
        assert property (fault_reset |-> $past(op) inside {OP_CALL, OP_PUSH, OP_IRQ,
        OP_RETURN, OP_POP}) else $error("stray fault_reset");
    a_read_latency:
        assert property (s_ar_taken |=> s_axi_rvalid) else $error("late read data");
    a_read_hold:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_ar_refused:
        assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    a_write_latency:
        assert property (s_wr_both |-> ##[2:3] s_axi_bvalid) else $error("late write response");
endmodule // ras_checker

bind return_address_stack ras_checker #(.ENTRIES(ENTRIES)) i_chk (.mclk, .nrst, .por,
    .dev_reset, .op, .op_fast, .live_regs, .pc_load, .shadow_regs, .shadow_load,
    .fault_reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready);

// [ras_seq_model.sv]
/*
 * Behavioural instruction sequencer facing the stack: issues one stack
 * operation per call and turns fault_reset into a device reset.
 * Assumes the bench calls do_op from a single process.
 */
`timescale 1ns/1ns
module ras_seq_model (
    input wire logic                    mclk,
    input wire logic                    fault_reset,
    output ras_pkg::stack_op_type       op,
    output logic                        op_fast,
    output logic [ras_pkg::PC_W-1:0]    pc_in,
    output logic [23:0]                 live_regs,
    output logic                        dev_reset
);
    import ras_pkg::*;
    int n_fault;
    initial begin
        op = OP_NONE;
        op_fast = 1'b0;
        pc_in = '0;
        live_regs = '0;
        dev_reset = 1'b0;
        n_fault = 0;
    end
    always @(posedge mclk) begin
        dev_reset <= fault_reset;
        if (fault_reset === 1'b1)
            n_fault <= n_fault + 1;
    end
    // ops only between bus accesses, even addresses
    task do_op(input stack_op_type o, input logic f, input logic [20:0] pc,
               input logic [23:0] regs);
        @(posedge mclk);
        op <= o;
        op_fast <= f;
        pc_in <= {pc[20:1], 1'b0};
        live_regs <= regs;
        @(posedge mclk);
        op <= OP_NONE;
        op_fast <= 1'b0;
    endtask
endmodule // ras_seq_model

// [return_address_stack_tb.sv]
/*
 * Self-checking bench for the return address stack: an AXI4-Lite master
 * reaches the registers, the sequencer model issues stack operations.
 * Assumes the design answers each bus request in a few cycles.
 */
`timescale 1ns/1ns
module return_address_stack_tb;
    import ras_pkg::*;
    logic                  mclk, nrst, por, dev_reset, op_fast, pc_load, shadow_load, fault_reset;
    stack_op_type          op;
    logic [20:0]           pc_in, pc_out;
    logic [23:0]           live_regs, shadow_regs;
    logic [7:0]            s_axi_awaddr, s_axi_araddr;
    logic [31:0]           s_axi_wdata, s_axi_rdata;
    logic [3:0]            s_axi_wstrb;
    logic [1:0]            s_axi_bresp, s_axi_rresp;
    logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                  s_axi_rvalid, s_axi_rready;
    logic [33:0]           v;
    logic [1:0]            b_seen;
    int                    num_errors = 0;
    int                    checked = 0;

    return_address_stack #(.ENTRIES(DEPTH)) i_dut (.mclk, .nrst, .por, .dev_reset, .op,
        .op_fast, .pc_in, .live_regs, .pc_out, .pc_load, .shadow_regs, .shadow_load,
        .fault_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    ras_seq_model i_seq (.mclk, .fault_reset, .op, .op_fast, .pc_in, .live_regs, .dev_reset);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task chk(input string n, input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task axw(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        b_seen = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task axr(input logic [7:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        v = {s_axi_rresp, s_axi_rdata};
        s_axi_rready <= 1'b0;
    endtask

    task rchk(input logic [7:0] a, input logic [7:0] e);
        axr(a);
        chk("register", v, {RESP_OKAY, 24'h0, e});
    endtask

    task top(input logic [20:0] pc);
        rchk(OFF_TOP_LOW, pc[7:0]);
        rchk(OFF_TOP_HIGH, pc[15:8]);
        rchk(OFF_TOP_UPR, {3'h0, pc[20:16]});
    endtask

    task wrap_up;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        wrap_up;
    end

    initial begin
        nrst = 1'b0;
        por = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'h1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        rchk(OFF_PTR, PTR_REG_RST);
        rchk(OFF_CONFIG, {7'h0, FRE_RST});
        axw(OFF_CONFIG, 8'h00);
        i_seq.do_op(OP_CALL, 1'b0, 21'h1a2b3c, 24'h0);
        rchk(OFF_PTR, 8'h01);
        top(21'h1a2b3c);
        i_seq.do_op(OP_PUSH, 1'b0, 21'h00f0f2, 24'h0);
        rchk(OFF_PTR, 8'h02);
        top(21'h00f0f2);
        i_seq.do_op(OP_POP, 1'b0, 21'h0, 24'h0);
        rchk(OFF_PTR, 8'h01);
        top(21'h1a2b3c);
        i_seq.do_op(OP_RETURN, 1'b0, 21'h0, 24'h0);
        #1 chk("pc_out", {12'h0, pc_load, pc_out}, {12'h0, 1'b1, 21'h1a2b3c});
        rchk(OFF_PTR, 8'h00);
        i_seq.do_op(OP_POP, 1'b0, 21'h0, 24'h0);
        rchk(OFF_PTR, 8'h40);
        i_seq.do_op(OP_RETURN, 1'b0, 21'h0, 24'h0);
        #1 chk("pc_out empty", {12'h0, pc_load, pc_out}, {12'h0, 1'b1, 21'h0});
        axw(OFF_PTR, 8'he5);
        rchk(OFF_PTR, 8'h45);
        axw(OFF_PTR, 8'h05);
        chk("bresp", {32'h0, b_seen}, {32'h0, RESP_OKAY});
        rchk(OFF_PTR, 8'h05);
        axw(OFF_TOP_LOW, 8'h34);
        rchk(OFF_TOP_LOW, 8'h34);
        axr(8'h20);
        chk("unmapped", v, {RESP_SLVERR, 32'h0});
        axw(8'h20, 8'h00);
        chk("bresp unmapped", {32'h0, b_seen}, {32'h0, RESP_SLVERR});
        axw(OFF_PTR, 8'h00);
        for (int i = 1; i <= 31; i++)
            i_seq.do_op(OP_CALL, 1'b0, 21'(2 * i), 24'h0);
        rchk(OFF_PTR, 8'h9f);
        i_seq.do_op(OP_CALL, 1'b0, 21'h1ffffe, 24'h0);
        rchk(OFF_PTR, 8'h9f);
        top(21'd62);
        @(posedge mclk);
        por <= 1'b1;
        @(posedge mclk);
        por <= 1'b0;
        rchk(OFF_PTR, 8'h00);
        axw(OFF_CONFIG, 8'h01);
        for (int i = 1; i <= 31; i++)
            i_seq.do_op(OP_CALL, 1'b0, 21'(4 * i), 24'h0);
        repeat (3) @(posedge mclk);
        chk("fault count", 34'(i_seq.n_fault), 34'd1);
        rchk(OFF_PTR, 8'h80);
        axw(OFF_PTR, 8'h00);
        i_seq.do_op(OP_POP, 1'b0, 21'h0, 24'h0);
        repeat (3) @(posedge mclk);
        chk("fault count", 34'(i_seq.n_fault), 34'd2);
        rchk(OFF_PTR, 8'h40);
        i_seq.do_op(OP_CALL, 1'b1, 21'h000100, 24'h123456);
        i_seq.do_op(OP_RETURN, 1'b1, 21'h0, 24'h0);
        #1 chk("shadow", {9'h0, shadow_load, shadow_regs}, {9'h0, 1'b1, 24'h123456});
        i_seq.do_op(OP_IRQ, 1'b0, 21'h000200, 24'haaaaaa);
        i_seq.do_op(OP_IRQ, 1'b0, 21'h000300, 24'h555555);
        top(21'h000300);
        i_seq.do_op(OP_RETURN, 1'b1, 21'h0, 24'h0);
        #1 chk("shadow", {9'h0, shadow_load, shadow_regs}, {9'h0, 1'b1, 24'h555555});
        wrap_up;
    end
endmodule // return_address_stack_tb
